// ### design/frpim_regs.vh
// Opcodes, phase lengths, state codes and timing counts for the flash command block.
// Assumes a 50 MHz system clock; all times are converted to cycles of that clock.
`ifndef FRPIM_REGS_VH
`define FRPIM_REGS_VH

`define FRPIM_CLK_MHZ        50
`define FRPIM_OP_RESUME      8'h7A
`define FRPIM_OP_SUSPEND     8'h75
`define FRPIM_OP_PWR_DOWN    8'hB9
`define FRPIM_OP_RELEASE_ID  8'hAB
`define FRPIM_OP_MFR_DEV_ID  8'h90
`define FRPIM_OP_MFR_DEV_2IO 8'h92
`define FRPIM_OP_MFR_DEV_4IO 8'h94
`define FRPIM_OP_JEDEC_ID    8'h9F
`define FRPIM_OP_QUAD_ON     8'h38
`define FRPIM_OP_QUAD_OFF    8'hFF

// Clocks per phase: code, address, dummy (serial, dual, quad lanes)
`define FRPIM_CODE_CLK_1     5'h08
`define FRPIM_CODE_CLK_4     5'h02
`define FRPIM_ADDR_CLK_1     5'h18
`define FRPIM_ADDR_CLK_2     5'h0C
`define FRPIM_ADDR_CLK_4     5'h06
`define FRPIM_DUM_CLK_2      5'h04
`define FRPIM_DUM_CLK_4      5'h06
`define FRPIM_DUM_CLK_RID    5'h18
`define FRPIM_LANE_1         3'h1
`define FRPIM_LANE_2         3'h2
`define FRPIM_LANE_4         3'h4

// Byte sequences on the output lanes
`define FRPIM_SEQ_DEV        2'h0
`define FRPIM_SEQ_MFR_DEV    2'h1
`define FRPIM_SEQ_JEDEC      2'h2

// Frame states
`define FRPIM_ST_IDLE        3'h0
`define FRPIM_ST_CODE        3'h1
`define FRPIM_ST_ADDR        3'h2
`define FRPIM_ST_DUM         3'h3
`define FRPIM_ST_DATA        3'h4
`define FRPIM_ST_DONE        3'h5
`define FRPIM_ST_IGN         3'h6

// Times in ns and cycle counts at 50 MHz; the entry count is sized for its 8-bit counter
`define FRPIM_RESUME_BUSY_NS 200
`define FRPIM_RESUME_BUSY_CYC ((`FRPIM_RESUME_BUSY_NS * `FRPIM_CLK_MHZ) / 1000)
`define FRPIM_TDP_NS         3000
`define FRPIM_TDP_CYC        8'h96

`endif

// ### design/frpim_sync.v
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; only the second stage is read outside.
module frpim_sync #(
    parameter WIDTH = 1
) (
    input  wire             i_clk,
    input  wire             i_arst_n,
    input  wire             i_ce,
    input  wire [WIDTH-1:0] i_d,
    output reg  [WIDTH-1:0] o_q
);
    reg [WIDTH-1:0] meta_ff;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_ff <= {WIDTH{1'b1}};
            o_q     <= {WIDTH{1'b1}};
        end else if (i_ce) begin
            meta_ff <= i_d;
            o_q     <= meta_ff;
        end
    end
endmodule

// ### design/frpim_top.v
// Serial flash command logic: resume, suspend, deep power down, ID reads, quad command mode.
// Assumes the host drives chip select and SCK; SCK is oversampled by I_CLK (at least 6x).
// Assumes the array engine reports its self-timed cycle on I_CORE_BUSY on this clock.
`include "frpim_regs.vh"

//
// Function
// - Resume is taken only while suspended and not busy.
// - Accepted resume clears suspend at once, raises busy quickly, restarts the array cycle.
// - Resume with suspend clear or busy set is ignored, state untouched.
// - Power loss clears suspend, so a later resume is refused.
// - Power down executes only if chip select rises right after its eighth bit.
// - Power down state is entered after the entry delay following chip select high.
// - In power down only the release/ID code is recognised; all else ignored.
// - Power down ends with power removal; power-up starts in standby.
// - Release code with chip select high leaves power down; host then waits.
// - Release/ID returns the ID only in serial mode; quad mode only releases.
// - ID read takes three dummy bytes, then repeats the ID byte MSB first.
// - Release/ID is ignored while busy; the running cycle is unaffected.
// - Address bit zero picks maker or device byte first; bytes then alternate.
// - Dual and quad ID reads use dual and quad lane timing.
// - Standard ID read sends maker, type, capacity bytes, repeating until deselect.
// - One command mode at a time; only the quad-enable code enters quad mode.
// - Quad-enable code acts only when the quad enable bit is set.
// - After power-up the device is in serial command mode.
// - Entering quad mode keeps write latch, suspend state and wrap length.
// - Quad-disable code returns to serial mode keeping the same state.
// - Accepted suspend sets suspend flag at once; busy drops within the latency.
// - Busy reads one during a self-timed cycle and zero after it.
module frpim_top #(
    parameter [7:0] MFR_ID   = 8'hA5, // Arbitrary value
    parameter [7:0] DEV_ID   = 8'h5A, // Arbitrary value
    parameter [7:0] MEM_TYPE = 8'h3C, // Arbitrary value
    parameter [7:0] CAPACITY = 8'hC3  // Arbitrary value
) (
    input  wire       I_CLK,
    input  wire       I_ARST_N,
    input  wire       I_CE,
    input  wire       I_CS_N,
    input  wire       I_SCK,
    input  wire [3:0] I_IO,
    input  wire       I_QUAD_ENABLE_BIT,
    input  wire       I_CORE_BUSY,
    output reg  [3:0] O_IO,
    output reg  [3:0] O_IO_OE,
    output reg        O_SUSPEND_FLAG,
    output reg        O_BUSY_FLAG,
    output reg        O_FOUR_LINE_COMMAND_MODE,
    output reg        O_DEEP_POWER_DOWN,
    output reg        O_CORE_RESUME,
    output reg        O_CORE_SUSPEND
);
    localparam [7:0] TDP_CYC = `FRPIM_TDP_CYC;

    wire [5:0] pins_s;
    wire       cs_n_s = pins_s[5];
    wire       sck_s  = pins_s[4];
    wire [3:0] io_s   = pins_s[3:0];

    reg        sck_d_ff;
    reg        cs_d_ff;
    reg  [2:0] st_ff;
    reg  [4:0] cnt_ff;
    reg  [4:0] dum_ff;
    reg  [2:0] lane_ff;
    reg  [1:0] seq_ff;
    reg  [7:0] code_ff;
    reg        rel_arm_ff;
    reg  [7:0] out_sh_ff;
    reg  [3:0] rem_ff;
    reg  [1:0] idx_ff;
    reg        busy_pend_ff;
    reg        pd_run_ff;
    reg  [7:0] pd_cnt_ff;

    wire sck_rise = sck_s & ~sck_d_ff;
    wire sck_fall = ~sck_s & sck_d_ff;
    wire cs_fall  = ~cs_n_s & cs_d_ff;
    wire cs_rise  = cs_n_s & ~cs_d_ff;
    wire four_line_command_mode      = O_FOUR_LINE_COMMAND_MODE;
    wire busy     = O_BUSY_FLAG;

    // Quad mode takes the high nibble first, serial mode one bit on IO0
    wire [7:0] nxt_code = four_line_command_mode ? {code_ff[3:0], io_s} : {code_ff[6:0], io_s[0]};

    frpim_sync #(
        .WIDTH(6)
    ) u_sync (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_ce     (I_CE),
        .i_d      ({I_CS_N, I_SCK, I_IO}),
        .o_q      (pins_s)
    );

    function [7:0] id_byte;
        input [1:0] seq;
        input [1:0] idx;
        begin
            case (seq)
                `FRPIM_SEQ_MFR_DEV: id_byte = idx[0] ? DEV_ID : MFR_ID;
                `FRPIM_SEQ_JEDEC:   id_byte = (idx == 2'h0) ? MFR_ID :
                                              (idx == 2'h1) ? MEM_TYPE : CAPACITY;
                default:            id_byte = DEV_ID;
            endcase
        end
    endfunction
    function [1:0] id_next;
        input [1:0] seq;
        input [1:0] idx;
        begin
            case (seq)
                `FRPIM_SEQ_MFR_DEV: id_next = {1'b0, ~idx[0]};
                `FRPIM_SEQ_JEDEC:   id_next = (idx == 2'h2) ? 2'h0 : idx + 2'h1;
                default:            id_next = 2'h0;
            endcase
        end
    endfunction
    // Top bits of a byte placed on the lanes that the current read uses
    function [3:0] lane_out;
        input [2:0] lane;
        input [7:0] b;
        begin
            case (lane)
                `FRPIM_LANE_4: lane_out = b[7:4];
                `FRPIM_LANE_2: lane_out = {2'b00, b[7:6]};
                default:       lane_out = {2'b00, b[7], 1'b0};
            endcase
        end
    endfunction
    function [3:0] lane_oe;
        input [2:0] lane;
        begin
            case (lane)
                `FRPIM_LANE_4: lane_oe = 4'hF;
                `FRPIM_LANE_2: lane_oe = 4'h3;
                default:       lane_oe = 4'h2;
            endcase
        end
    endfunction

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sck_d_ff                 <= 1'b1;
            cs_d_ff                  <= 1'b1;
            st_ff                    <= `FRPIM_ST_IDLE;
            cnt_ff                   <= 5'h00;
            dum_ff                   <= 5'h00;
            lane_ff                  <= `FRPIM_LANE_1;
            seq_ff                   <= `FRPIM_SEQ_DEV;
            code_ff                  <= 8'h00;
            rel_arm_ff               <= 1'b0;
            out_sh_ff                <= 8'h00;
            rem_ff                   <= 4'h0;
            idx_ff                   <= 2'h0;
            busy_pend_ff             <= 1'b0;
            pd_run_ff                <= 1'b0;
            pd_cnt_ff                <= 8'h00;
            O_IO                     <= 4'h0;
            O_IO_OE                  <= 4'h0;
            O_SUSPEND_FLAG           <= 1'b0;
            O_BUSY_FLAG              <= 1'b0;
            O_FOUR_LINE_COMMAND_MODE <= 1'b0;
            O_DEEP_POWER_DOWN        <= 1'b0;
            O_CORE_RESUME            <= 1'b0;
            O_CORE_SUSPEND           <= 1'b0;
        end else if (I_CE) begin
            sck_d_ff       <= sck_s;
            cs_d_ff        <= cs_n_s;
            O_CORE_RESUME  <= 1'b0;
            O_CORE_SUSPEND <= 1'b0;
            // Pending flag bridges the gap until the array engine reports busy
            O_BUSY_FLAG    <= I_CORE_BUSY | busy_pend_ff;
            if (I_CORE_BUSY) begin
                busy_pend_ff <= 1'b0;
            end
            if (pd_run_ff) begin
                if (pd_cnt_ff <= 8'h01) begin
                    pd_run_ff         <= 1'b0;
                    O_DEEP_POWER_DOWN <= 1'b1;
                end else begin
                    pd_cnt_ff <= pd_cnt_ff - 8'h01;
                end
            end
            if (cs_rise) begin
                st_ff   <= `FRPIM_ST_IDLE;
                O_IO_OE <= 4'h0;
                if (rel_arm_ff && !busy) begin
                    O_DEEP_POWER_DOWN <= 1'b0;
                    pd_run_ff         <= 1'b0;
                end
                if (st_ff == `FRPIM_ST_DONE) begin
                    case (code_ff)
                        `FRPIM_OP_PWR_DOWN: begin
                            pd_run_ff <= 1'b1;
                            pd_cnt_ff <= TDP_CYC;
                        end
                        `FRPIM_OP_RESUME: begin
                            if (O_SUSPEND_FLAG && !busy) begin
                                O_SUSPEND_FLAG <= 1'b0;
                                O_CORE_RESUME  <= 1'b1;
                                busy_pend_ff   <= 1'b1;
                            end
                        end
                        `FRPIM_OP_SUSPEND: begin
                            if (!O_SUSPEND_FLAG && busy) begin
                                O_SUSPEND_FLAG <= 1'b1;
                                O_CORE_SUSPEND <= 1'b1;
                            end
                        end
                        `FRPIM_OP_QUAD_ON: begin
                            // Only the mode bit moves; latch, suspend and wrap stay
                            if (!four_line_command_mode && I_QUAD_ENABLE_BIT) begin
                                O_FOUR_LINE_COMMAND_MODE <= 1'b1;
                            end
                        end
                        `FRPIM_OP_QUAD_OFF: begin
                            if (four_line_command_mode) begin
                                O_FOUR_LINE_COMMAND_MODE <= 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end else if (cs_fall) begin
                st_ff      <= `FRPIM_ST_CODE;
                cnt_ff     <= four_line_command_mode ? `FRPIM_CODE_CLK_4 : `FRPIM_CODE_CLK_1;
                code_ff    <= 8'h00;
                rel_arm_ff <= 1'b0;
                O_IO_OE    <= 4'h0;
            end else if (sck_rise && !cs_n_s) begin
                case (st_ff)
                    `FRPIM_ST_CODE: begin
                        code_ff <= nxt_code;
                        cnt_ff  <= cnt_ff - 5'h01;
                        if (cnt_ff == 5'h01) begin
                            if (O_DEEP_POWER_DOWN && nxt_code != `FRPIM_OP_RELEASE_ID) begin
                                st_ff <= `FRPIM_ST_IGN;
                            end else begin
                                case (nxt_code)
                                    `FRPIM_OP_RELEASE_ID: begin
                                        if (busy) begin
                                            st_ff <= `FRPIM_ST_IGN;
                                        end else begin
                                            rel_arm_ff <= 1'b1;
                                            // Quad mode has no ID phase: release only
                                            st_ff   <= four_line_command_mode ? `FRPIM_ST_DONE : `FRPIM_ST_DUM;
                                            cnt_ff  <= `FRPIM_DUM_CLK_RID;
                                            lane_ff <= `FRPIM_LANE_1;
                                            seq_ff  <= `FRPIM_SEQ_DEV;
                                        end
                                    end
                                    `FRPIM_OP_MFR_DEV_ID: begin
                                        st_ff   <= `FRPIM_ST_ADDR;
                                        cnt_ff  <= four_line_command_mode ? `FRPIM_ADDR_CLK_4 : `FRPIM_ADDR_CLK_1;
                                        dum_ff  <= 5'h00;
                                        lane_ff <= four_line_command_mode ? `FRPIM_LANE_4 : `FRPIM_LANE_1;
                                        seq_ff  <= `FRPIM_SEQ_MFR_DEV;
                                    end
                                    `FRPIM_OP_MFR_DEV_2IO: begin
                                        st_ff   <= four_line_command_mode ? `FRPIM_ST_IGN : `FRPIM_ST_ADDR;
                                        cnt_ff  <= `FRPIM_ADDR_CLK_2;
                                        dum_ff  <= `FRPIM_DUM_CLK_2;
                                        lane_ff <= `FRPIM_LANE_2;
                                        seq_ff  <= `FRPIM_SEQ_MFR_DEV;
                                    end
                                    `FRPIM_OP_MFR_DEV_4IO: begin
                                        st_ff   <= four_line_command_mode ? `FRPIM_ST_IGN : `FRPIM_ST_ADDR;
                                        cnt_ff  <= `FRPIM_ADDR_CLK_4;
                                        dum_ff  <= `FRPIM_DUM_CLK_4;
                                        lane_ff <= `FRPIM_LANE_4;
                                        seq_ff  <= `FRPIM_SEQ_MFR_DEV;
                                    end
                                    `FRPIM_OP_JEDEC_ID: begin
                                        st_ff   <= `FRPIM_ST_DATA;
                                        lane_ff <= four_line_command_mode ? `FRPIM_LANE_4 : `FRPIM_LANE_1;
                                        seq_ff  <= `FRPIM_SEQ_JEDEC;
                                        idx_ff  <= 2'h0;
                                        rem_ff  <= 4'h0;
                                    end
                                    `FRPIM_OP_PWR_DOWN, `FRPIM_OP_RESUME, `FRPIM_OP_SUSPEND,
                                    `FRPIM_OP_QUAD_ON, `FRPIM_OP_QUAD_OFF: begin
                                        st_ff <= `FRPIM_ST_DONE;
                                    end
                                    default: begin
                                        st_ff <= `FRPIM_ST_IGN;
                                    end
                                endcase
                            end
                        end
                    end
                    `FRPIM_ST_ADDR: begin
                        cnt_ff <= cnt_ff - 5'h01;
                        if (cnt_ff == 5'h01) begin
                            // IO0 carries A0 on the last address clock for every lane width
                            idx_ff <= {1'b0, io_s[0]};
                            rem_ff <= 4'h0;
                            st_ff  <= (dum_ff == 5'h00) ? `FRPIM_ST_DATA : `FRPIM_ST_DUM;
                            cnt_ff <= dum_ff;
                        end
                    end
                    `FRPIM_ST_DUM: begin
                        cnt_ff <= cnt_ff - 5'h01;
                        if (cnt_ff == 5'h01) begin
                            st_ff <= `FRPIM_ST_DATA;
                            if (seq_ff == `FRPIM_SEQ_DEV) begin
                                idx_ff <= 2'h0;
                                rem_ff <= 4'h0;
                            end
                        end
                    end
                    `FRPIM_ST_DONE: begin
                        // A clock past the code byte voids the instruction, unless it is a release
                        st_ff <= `FRPIM_ST_IGN;
                    end
                    default: begin
                    end
                endcase
            end else if (sck_fall && !cs_n_s && st_ff == `FRPIM_ST_DATA) begin
                O_IO_OE <= lane_oe(lane_ff);
                if (rem_ff == 4'h0) begin
                    O_IO      <= lane_out(lane_ff, id_byte(seq_ff, idx_ff));
                    out_sh_ff <= id_byte(seq_ff, idx_ff) << lane_ff;
                    rem_ff    <= 4'h8 - {1'b0, lane_ff};
                    idx_ff    <= id_next(seq_ff, idx_ff);
                end else begin
                    O_IO      <= lane_out(lane_ff, out_sh_ff);
                    out_sh_ff <= out_sh_ff << lane_ff;
                    rem_ff    <= rem_ff - {1'b0, lane_ff};
                end
            end
        end
    end
endmodule

// ### verif/frpim_props.sv
// Checker for the flash command block, bound to its top module.
// Assumes one domain: I_CLK with the asynchronous reset I_ARST_N.
module frpim_props (
    input wire       I_CLK,
    input wire       I_ARST_N,
    input wire       I_CE,
    input wire       I_CS_N,
    input wire       I_SCK,
    input wire [3:0] I_IO,
    input wire       I_QUAD_ENABLE_BIT,
    input wire       I_CORE_BUSY,
    input wire [3:0] O_IO,
    input wire [3:0] O_IO_OE,
    input wire       O_SUSPEND_FLAG,
    input wire       O_BUSY_FLAG,
    input wire       O_FOUR_LINE_COMMAND_MODE,
    input wire       O_DEEP_POWER_DOWN,
    input wire       O_CORE_RESUME,
    input wire       O_CORE_SUSPEND
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    resume_gate_a: assert property (
        O_CORE_RESUME |-> $past(O_SUSPEND_FLAG) && !$past(O_BUSY_FLAG))
        else $error("resume without suspend");
    resume_busy_a: assert property (
        O_CORE_RESUME |-> !O_SUSPEND_FLAG ##[1:10] O_BUSY_FLAG)
        else $error("resume did not raise busy");
    suspend_keep_a: assert property (
        $fell(O_SUSPEND_FLAG) |-> O_CORE_RESUME)
        else $error("suspend cleared without resume");
    suspend_set_a: assert property (
        O_CORE_SUSPEND |-> O_SUSPEND_FLAG && !$past(O_SUSPEND_FLAG) && $past(O_BUSY_FLAG))
        else $error("bad suspend");
    busy_follow_a: assert property (
        $past(I_CORE_BUSY) && $past(I_ARST_N) |-> O_BUSY_FLAG)
        else $error("busy flag low during cycle");
    pd_entry_a: assert property (
        $rose(O_DEEP_POWER_DOWN) |-> I_CS_N && $past(I_CS_N, 140))
        else $error("power down entered early");
    pd_release_a: assert property (
        $fell(O_DEEP_POWER_DOWN) |-> !$past(O_BUSY_FLAG))
        else $error("release while busy");
    quad_gate_a: assert property (
        $rose(O_FOUR_LINE_COMMAND_MODE) |-> $past(I_QUAD_ENABLE_BIT))
        else $error("quad mode without enable bit");
endmodule
bind frpim_top frpim_props frpim_props_inst (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_CE(I_CE), .I_CS_N(I_CS_N), .I_SCK(I_SCK),
    .I_IO(I_IO), .I_QUAD_ENABLE_BIT(I_QUAD_ENABLE_BIT), .I_CORE_BUSY(I_CORE_BUSY),
    .O_IO(O_IO), .O_IO_OE(O_IO_OE), .O_SUSPEND_FLAG(O_SUSPEND_FLAG),
    .O_BUSY_FLAG(O_BUSY_FLAG), .O_FOUR_LINE_COMMAND_MODE(O_FOUR_LINE_COMMAND_MODE),
    .O_DEEP_POWER_DOWN(O_DEEP_POWER_DOWN), .O_CORE_RESUME(O_CORE_RESUME),
    .O_CORE_SUSPEND(O_CORE_SUSPEND));

// ### verif/frpim_host.sv
// Host model: drives chip select, SCK in mode 0 and the data lanes.
// Assumes the block's system clock; lines change only on its falling edge.
module frpim_host (
    input  wire        i_clk,
    input  wire  [3:0] i_io,
    input  wire  [3:0] i_oe,
    output logic       o_cs_n,
    output logic       o_sck,
    output logic [3:0] o_io
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rd;
    logic       oe_seen;
    event       got;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_io = 4'h0;
    end
    // Lanes sampled just before the rise, well after the device's update
    task automatic tick(input logic [3:0] v, output logic [3:0] r);
        o_io = v;
        repeat (4) @(negedge i_clk);
        r = i_io ^ ~i_oe; // Released lanes read as the inverse of the last level
        oe_seen |= |i_oe;
        o_sck = 1'b1;
        repeat (4) @(negedge i_clk);
        o_sck = 1'b0;
    endtask
    task automatic frame(input logic [7:0] c, input int ql, nm, lv, rl, nb);
        logic [3:0] r;
        logic [7:0] b;
        oe_seen = 1'b0;
        o_cs_n = 1'b0;
        for (int i = 8 / ql - 1; i >= 0; i--) tick((ql == 4) ? c[4*i+:4] : {3'h0, c[i]}, r);
        for (int i = 1; i <= nm; i++) tick((i == nm) ? 4'(lv) : 4'h0, r);
        for (int k = 0; k < nb; k++) begin
            for (int j = 0; j < 8 / rl; j++) begin
                tick(~o_io, r); // Released lanes toggle so a stale level cannot match
                b = (rl == 4) ? {b[3:0], r} : (rl == 2) ? {b[5:0], r[1:0]} : {b[6:0], r[1]};
            end
            rd = b;
            -> got;
        end
        o_cs_n = 1'b1;
        o_io = ~o_io;
        repeat (8) @(negedge i_clk); // Deselect time before the next frame
    endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the flash command block with a host model on the link.
// Assumes design, checker and host model compiled first; inputs change on falling edges.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MFR = 8'h6B; // Arbitrary value
    localparam logic [7:0] DEV = 8'h2E; // Arbitrary value
    localparam logic [7:0] MT = 8'h81;  // Arbitrary value
    localparam logic [7:0] CP = 8'h47;  // Arbitrary value
    logic       clk, arst_n, qe, core_busy, ce, cs_n, sck, susp, busy, quad, dpd;
    logic [3:0] hio, dio, doe;
    logic [7:0] exp_q[$];
    logic [7:0] jed[3] = '{MFR, MT, CP};
    logic [7:0] ops[4] = '{8'h90, 8'h90, 8'h92, 8'h94};
    int         mids[4] = '{24, 24, 16, 12};
    int         lns[4] = '{1, 1, 2, 4};
    int         error_cnt, n_compared, seed, n;
    frpim_host frpim_host_inst (.i_clk(clk), .i_io(dio), .i_oe(doe), .o_cs_n(cs_n),
        .o_sck(sck), .o_io(hio));
    frpim_top #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MT), .CAPACITY(CP)) frpim_top_inst (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_CS_N(cs_n), .I_SCK(sck), .I_IO(hio),
        .I_QUAD_ENABLE_BIT(qe), .I_CORE_BUSY(core_busy), .O_IO(dio), .O_IO_OE(doe),
        .O_SUSPEND_FLAG(susp), .O_BUSY_FLAG(busy), .O_FOUR_LINE_COMMAND_MODE(quad),
        .O_DEEP_POWER_DOWN(dpd), .O_CORE_RESUME(), .O_CORE_SUSPEND());
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic f(input logic [7:0] c, input int ql, nm, lv, rl, nb);
        frpim_host_inst.frame(c, ql, nm, lv, rl, nb);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Every byte the host reads is matched against the oldest note
    always @(frpim_host_inst.got) chk("id", exp_q.pop_front(), frpim_host_inst.rd);
    initial begin
        #1000000;
        error_cnt++;
        conclude();
    end
    initial begin
        seed = 47988;
        arst_n = 1'b0;
        qe = 1'b0;
        core_busy = 1'b0;
        ce = 1'b1;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("mode", 8'h00, 8'(quad));
        n = 2 + ($random(seed) & 3);
        for (int i = 0; i < n; i++) exp_q.push_back(jed[i % 3]);
        f(8'h9F, 1, 0, 0, 1, n);
        for (int t = 0; t < 4; t++) begin
            for (int i = 0; i < 3; i++) exp_q.push_back(((i + (t == 1)) % 2) ? DEV : MFR);
            f(ops[t], 1, mids[t], (t == 1), lns[t], 3);
        end
        for (int i = 0; i < 2; i++) exp_q.push_back(DEV);
        f(8'hAB, 1, 24, 0, 1, 2);
        $display("id reads done");
        f(8'hB9, 1, 1, 0, 1, 0);
        repeat (160) @(negedge clk);
        chk("dpd", 8'h00, 8'(dpd));
        f(8'hB9, 1, 0, 0, 1, 0);
        // A frozen clock enable must stretch the entry delay by the frozen span
        ce = 1'b0;
        repeat (40) @(negedge clk);
        ce = 1'b1;
        repeat (120) @(negedge clk);
        chk("dpd", 8'h00, 8'(dpd));
        repeat (40) @(negedge clk);
        chk("dpd", 8'h01, 8'(dpd));
        f(8'h9F, 1, 16, 0, 1, 0);
        chk("oe", 8'h00, 8'(frpim_host_inst.oe_seen));
        core_busy = 1'b1;
        f(8'hAB, 1, 0, 0, 1, 0);
        chk("dpd", 8'h01, 8'(dpd));
        f(8'h75, 1, 0, 0, 1, 0);
        chk("susp", 8'h00, 8'(susp));
        core_busy = 1'b0;
        f(8'hAB, 1, 0, 0, 1, 0);
        chk("dpd", 8'h00, 8'(dpd));
        $display("power down done");
        core_busy = 1'b1;
        f(8'h75, 1, 0, 0, 1, 0);
        chk("susp", 8'h01, 8'(susp));
        core_busy = 1'b0;
        f(8'h38, 1, 0, 0, 1, 0);
        chk("mode", 8'h00, 8'(quad));
        qe = 1'b1;
        f(8'h38, 1, 0, 0, 1, 0);
        chk("mode", 8'h01, 8'(quad));
        chk("susp", 8'h01, 8'(susp));
        for (int i = 0; i < 3; i++) exp_q.push_back(jed[i]);
        f(8'h9F, 4, 0, 0, 4, 3);
        f(8'hB9, 4, 0, 0, 4, 0);
        repeat (160) @(negedge clk);
        chk("dpd", 8'h01, 8'(dpd));
        // Longer than the serial dummy phase, so a wrong ID phase would drive
        f(8'hAB, 4, 26, 0, 4, 0);
        chk("dpd", 8'h00, 8'(dpd));
        chk("oe", 8'h00, 8'(frpim_host_inst.oe_seen));
        f(8'hFF, 4, 0, 0, 4, 0);
        chk("mode", 8'h00, 8'(quad));
        chk("susp", 8'h01, 8'(susp));
        $display("mode switch done");
        core_busy = 1'b1;
        f(8'h7A, 1, 0, 0, 1, 0);
        chk("susp", 8'h01, 8'(susp));
        core_busy = 1'b0;
        repeat (2) @(negedge clk);
        f(8'h7A, 1, 0, 0, 1, 0);
        chk("susp", 8'h00, 8'(susp));
        chk("busy", 8'h01, 8'(busy));
        core_busy = 1'b1;
        repeat (20) @(negedge clk); // Suspend latency before a new suspend
        f(8'h75, 1, 0, 0, 1, 0);
        core_busy = 1'b0;
        f(8'hB9, 1, 0, 0, 1, 0);
        repeat (160) @(negedge clk);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("dpd", 8'h00, 8'(dpd));
        f(8'h7A, 1, 0, 0, 1, 0);
        chk("busy", 8'h00, 8'(busy));
        chk("left", 8'h00, 8'(exp_q.size()));
        $display("suspend and resume done");
        conclude();
    end
endmodule
